// ---- bench/artp_pin_model.sv ----
// Purpose: Far-side model of the timer input and PWM output pins
// Assumes: Pin levels change just after a rising hclk edge
// Notes:   Each level is held 9 cycles so the 3-flop synchroniser sees it
module artp_pin_model (
   hclk,     // System clock
   tim_in,   // Drives the timer input pin
   tim_out   // Watches the PWM pin
);
   timeunit 1ns;
   timeprecision 1ps;
   input  wire logic hclk;     // System clock
   output logic      tim_in;   // Timer input pin level
   input  wire logic tim_out;  // PWM pin level
   logic             saw_hi;   // PWM pin seen high
   logic             saw_lo;   // PWM pin seen low after high

   initial begin
      tim_in = 1'b0;
      saw_hi = 1'b0;
      saw_lo = 1'b0;
   end

   // ==========================================================
   // Watch the PWM pin for a full set then clear
   always @(posedge hclk) begin
      if (tim_out === 1'b1) begin
         saw_hi <= 1'b1;
      end
      if (tim_out === 1'b0 && saw_hi) begin
         saw_lo <= 1'b1;
      end
   end

   // Long hold: a short pulse could slip past the synchroniser
   task automatic drive(input logic v);
      @(posedge hclk);
      tim_in <= v;
      repeat (8) @(posedge hclk);
   endtask

   // Whole pulses used as an external count clock
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++) begin
         drive(1'b1);
         drive(1'b0);
      end
   endtask
endmodule

// ---- bench/tb_auto_reload_timer_pwm.sv ----
// Purpose: Self-checking bench for the auto-reload timer block
// Assumes: Zero-wait AHB-Lite slave; one 8-bit register per word
// Notes:   Counts are checked in windows where bus cycles blur timing
module tb_auto_reload_timer_pwm;
   timeunit 1ns;
   timeprecision 1ps;
   import artp_pkg::*;
   logic        hclk      = 1'b0;     // System clock
   logic        hresetn   = 1'b0;     // Reset, active low
   logic [31:0] haddr     = '0;       // Byte address
   logic [1:0]  htrans    = 2'h0;     // Transfer type
   logic        hwrite    = 1'b0;     // Write flag
   logic        hsel      = 1'b1;     // Slave select
   logic [2:0]  hsize     = 3'h2;     // Transfer size, word
   logic [31:0] hwdata    = '0;       // Write data
   logic [31:0] hrdata;               // Read data
   logic        hreadyout;            // Slave ready, also bus ready
   logic        hresp;                // Response
   logic        tim_in;               // Timer input pin
   logic        tim_out;              // PWM pin
   logic        irq;                  // Combined interrupt
   logic [7:0]  v;                    // Last read value
   int          err_total = 0;        // Mismatches
   int          cmp_count = 0;        // Comparisons
   int          cyc       = 0;        // Timeout counter

   always #5 hclk = ~hclk;

   artp_timer artp_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tim_in(tim_in), .tim_out(tim_out), .irq(irq));
   artp_pin_model artp_pin_model_i (.hclk(hclk), .tim_in(tim_in), .tim_out(tim_out));

   // ==========================================================
   // Bus tasks: address phase held until ready, then data phase
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= 1'b1;
      hsize  <= 3'h2;
      haddr  <= {22'h0, ofs, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] ofs);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= 1'b0;
      hsize  <= 3'h2;
      haddr  <= {22'h0, ofs, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      v = hrdata[7:0];
   endtask

   // One comparison, counted; unknowns never match
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(ARTP_OFS_MODE);
      chk(v, ARTP_MODE_RST);
      chk({6'h0, irq, tim_out}, 8'h00);
      rd(8'hd8);
      chk(v, 8'h00);
      chk({6'h0, hreadyout, hresp}, 8'h02);         // Zero wait, OKAY
      hsel <= 1'b0;
      wr(ARTP_OFS_COMPARE, 8'h55);
      hsel <= 1'b1;
      rd(ARTP_OFS_COMPARE);
      chk(v, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_load;
      wr(ARTP_OFS_RELOAD, 8'h10);
      wr(ARTP_OFS_MODE, 8'h80);
      rd(ARTP_OFS_LIVE);
      chk(v, 8'h10);
      rd(ARTP_OFS_MODE);
      chk(v, 8'h00);
      repeat (5) @(posedge hclk);
      rd(ARTP_OFS_LIVE);
      chk(v, 8'h10);
      $display("test load done");
   endtask

   // Short period F0..FF so overflow and match both recur
   task automatic t_run;
      wr(ARTP_OFS_CLKEDGE, 8'h00);
      wr(ARTP_OFS_COMPARE, 8'hf8);
      rd(ARTP_OFS_COMPARE);
      chk(v, 8'hf8);
      wr(ARTP_OFS_RELOAD, 8'hf0);
      wr(ARTP_OFS_MODE, 8'hec);
      repeat (40) @(posedge hclk);
      rd(ARTP_OFS_LIVE);
      chk({4'h0, v[7:4]}, 8'h0f);
      wr(ARTP_OFS_MODE, 8'h2c);
      wr(ARTP_OFS_LIVE, 8'h00);
      rd(ARTP_OFS_FLAGS);
      chk(v, 8'h03);
      chk({7'h0, irq}, 8'h01);
      chk({6'h0, artp_pin_model_i.saw_hi, artp_pin_model_i.saw_lo}, 8'h03);
      wr(ARTP_OFS_FLAGS, 8'h06);
      rd(ARTP_OFS_FLAGS);
      chk(v, 8'h02);
      wr(ARTP_OFS_MODE, 8'h24);
      repeat (2) @(posedge hclk);
      chk({7'h0, irq}, 8'h00);
      wr(ARTP_OFS_COMPARE, 8'hef);                  // Never reached from F0
      wr(ARTP_OFS_LIVE, 8'hff);
      wr(ARTP_OFS_MODE, 8'h64);
      repeat (4) @(posedge hclk);
      chk({7'h0, tim_out}, 8'h01);
      wr(ARTP_OFS_MODE, 8'h04);
      repeat (3) @(posedge hclk);
      chk({7'h0, tim_out}, 8'h00);
      wr(ARTP_OFS_FLAGS, 8'h00);
      $display("test run done");
   endtask

   // Ratio 8, then divide-by-3: 81 counted edges give 10, then 27
   task automatic t_div;
      wr(ARTP_OFS_CLKEDGE, 8'h60);
      wr(ARTP_OFS_MODE, 8'h40);
      wr(ARTP_OFS_LIVE, 8'h00);
      repeat (80) @(posedge hclk);
      rd(ARTP_OFS_LIVE);
      chk(v, 8'h0a);
      wr(ARTP_OFS_CLKEDGE, 8'h01);
      wr(ARTP_OFS_LIVE, 8'h00);
      repeat (80) @(posedge hclk);
      rd(ARTP_OFS_LIVE);
      chk(v, 8'h1b);
      $display("test divider done");
   endtask

   task automatic t_edge;
      wr(ARTP_OFS_MODE, 8'h00);
      wr(ARTP_OFS_CLKEDGE, 8'h04);
      wr(ARTP_OFS_MODE, 8'h51);
      wr(ARTP_OFS_LIVE, 8'h00);
      artp_pin_model_i.drive(1'b1);
      rd(ARTP_OFS_FLAGS);
      chk(v, 8'h04);
      chk({7'h0, irq}, 8'h01);
      rd(ARTP_OFS_RELOAD);
      chk({7'h0, v != 8'h00 && v < 8'h20}, 8'h01);
      artp_pin_model_i.drive(1'b0);
      wr(ARTP_OFS_FLAGS, 8'h00);
      wr(ARTP_OFS_CLKEDGE, 8'h0c);
      artp_pin_model_i.drive(1'b1);
      rd(ARTP_OFS_FLAGS);
      chk(v, 8'h00);
      artp_pin_model_i.drive(1'b0);
      rd(ARTP_OFS_FLAGS);
      chk(v, 8'h04);
      wr(ARTP_OFS_CLKEDGE, 8'h04);
      wr(ARTP_OFS_MODE, 8'h03);
      wr(ARTP_OFS_RELOAD, 8'h40);
      wr(ARTP_OFS_LIVE, 8'h00);
      artp_pin_model_i.drive(1'b1);
      rd(ARTP_OFS_LIVE);
      chk(v, 8'h40);
      artp_pin_model_i.drive(1'b0);
      wr(ARTP_OFS_MODE, 8'h42);
      repeat (30) @(posedge hclk);
      artp_pin_model_i.drive(1'b1);
      rd(ARTP_OFS_LIVE);
      chk({7'h0, v < 8'h10}, 8'h01);
      artp_pin_model_i.drive(1'b0);
      $display("test edge done");
   endtask

   // Pin as count clock: five pulses, five counts
   task automatic t_pin;
      wr(ARTP_OFS_MODE, 8'h00);
      wr(ARTP_OFS_CLKEDGE, 8'h02);
      wr(ARTP_OFS_MODE, 8'h40);
      wr(ARTP_OFS_LIVE, 8'h00);
      artp_pin_model_i.pulses(5);
      rd(ARTP_OFS_LIVE);
      chk(v, 8'h05);
      $display("test pin clock done");
   endtask

   // ==========================================================
   // Closing report, reached once
   task automatic print_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         print_verdict();
      end
   end

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_load();
      t_run();
      t_div();
      t_edge();
      t_pin();
      print_verdict();
   end
endmodule

// ---- rtl/artp_pkg.sv ----
// Purpose: Shared constants for the auto-reload timer with PWM output
// Assumes: AHB-Lite register bus, 32-bit data, one register per aligned word
// Notes:   Offsets are register indices; byte address is index times four
package artp_pkg;

   // ==========================================================
   // Register indices
   localparam logic [7:0] ARTP_OFS_MODE    = 8'hd5;  // Mode control (index)
   localparam logic [7:0] ARTP_OFS_FLAGS   = 8'hd6;  // Status flags (index)
   localparam logic [7:0] ARTP_OFS_CLKEDGE = 8'hd7;  // Clock/edge config (index)
   localparam logic [7:0] ARTP_OFS_RELOAD  = 8'hd9;  // Reload/capture (index)
   localparam logic [7:0] ARTP_OFS_COMPARE = 8'hda;  // Compare value (index)
   localparam logic [7:0] ARTP_OFS_LIVE    = 8'hdb;  // Live load (index)
   localparam int         ARTP_IDX_SHIFT   = 2;      // Byte address = index * 4

   // ==========================================================
   // Mode control fields
   localparam int ARTP_B_LOAD  = 7;  // Counter load strobe
   localparam int ARTP_B_EN    = 6;  // Count enable
   localparam int ARTP_B_WOE   = 5;  // Wave output enable
   localparam int ARTP_B_EIE   = 4;  // Edge irq enable
   localparam int ARTP_B_MIE   = 3;  // Match irq enable
   localparam int ARTP_B_WIE   = 2;  // Wrap irq enable
   localparam int ARTP_B_MODE  = 0;  // Mode select field lsb

   // Status flags
   localparam int ARTP_B_EF    = 2;  // Edge flag
   localparam int ARTP_B_MF    = 1;  // Match flag
   localparam int ARTP_B_WF    = 0;  // Wrap flag

   // Clock/edge config fields
   localparam int ARTP_B_DIV   = 5;  // Divider select lsb
   localparam int ARTP_B_RSV   = 4;  // Reserved, kept zero
   localparam int ARTP_B_SLPOL = 3;  // Edge polarity (1 = falling)
   localparam int ARTP_B_SLEN  = 2;  // Edge detect enable
   localparam int ARTP_B_SRC   = 0;  // Source select lsb

   localparam logic [7:0] ARTP_MODE_RST = 8'h00;  // Mode control reset value
   localparam logic [7:0] ARTP_CNT_MAX  = 8'hff;  // Wrap point
   localparam logic [1:0] ARTP_DIV3_END = 2'h2;   // Divide-by-3 terminal count

   // Operating modes and clock sources
   typedef enum logic [1:0] {ARTP_AUTO, ARTP_CAP, ARTP_CAPRST, ARTP_EXTLD} artp_mode_t;
   typedef enum logic [1:0] {ARTP_SRC_INT, ARTP_SRC_DIV3, ARTP_SRC_PIN, ARTP_SRC_RSV} artp_src_t;

endpackage

// ---- rtl/artp_timer.sv ----
// Purpose: 8-bit auto-reload timer with PWM, capture and external load
// Assumes: One clock hclk (100 MHz); AHB-Lite slave, zero wait states
// Notes:   Timer input pin is asynchronous and passes a 3-flop synchroniser

// Contract
// - Load strobe copies reload value, clears prescaler
// - Load strobe bit always reads zero
// - Enable clear freezes prescaler and counting; counter loads still act
// - Wave output enable gates PWM pin
// - Edge irq when enable and flag set
// - Match irq when enable and flag set
// - Wrap irq when enable and flag set
// - Mode field selects four operating modes
// - Reset clears mode control register
// - Flags cleared by writing zero only
// - Active input edge sets edge flag
// - Counter equal compare sets match flag
// - Rollover from max to reload value sets wrap
// - Divider ratio two to field; counter untouched
// - Edge field: enable bit, polarity bit
// - Source field: internal, div3, pin, reserved
// - Live load reads/writes counter; no reset
// - Reload register reloads counter on overflow
// - Compare register holds match value
// - Overflow reloads, sets pin; match clears
// - Capture copies counter; reset variant clears
// - Extload edge copies reload into counter
// - Every counter load clears the prescaler
module artp_timer (
   input  wire logic        hclk,       // System clock
   input  wire logic        hresetn,    // Async reset, active low
   input  wire logic        hsel,       // Slave select
   input  wire logic [31:0] haddr,      // Byte address
   input  wire logic [1:0]  htrans,     // Transfer type
   input  wire logic        hwrite,     // Write when high
   input  wire logic [2:0]  hsize,      // Transfer size
   input  wire logic        hready,     // Bus ready in
   input  wire logic [31:0] hwdata,     // Write data
   output logic      [31:0] hrdata,     // Read data
   output logic             hreadyout,  // Always ready
   output logic             hresp,      // Always OKAY
   input  wire logic        tim_in,     // Timer input pin
   output logic             tim_out,    // Timer output pin
   output logic             irq         // Combined timer interrupt
);
   import artp_pkg::*;

   // ==========================================================
   // State
   logic [7:0]  mode_r;          // Mode control (bit 7 never stored)
   logic [2:0]  flags_r;         // Edge, match, wrap
   logic [7:0]  cfg_r;           // Clock/edge config
   logic [7:0]  reload_r;        // Reload/capture
   logic [7:0]  cmp_r;           // Compare value
   logic [7:0]  live_r;          // Live load, not reset
   logic [7:0]  cnt_r;           // Main counter
   logic [6:0]  psc_r;           // Prescaler counter
   logic [1:0]  div3_r;          // Divide-by-3 counter
   logic [2:0]  sync_r;          // Input synchroniser
   logic        pin_lvl_r;       // Filtered pin level
   logic        pwm_r;           // PWM waveform
   logic        wr_pend_r;       // Write data phase pending
   logic [7:0]  wr_addr_r;       // Latched write address
   logic        out_r;           // Registered pin
   logic        irq_r;           // Registered irq
   logic [31:0] rdata_r;         // Registered read data

   // ==========================================================
   // Bus decode
   wire         addr_ok   = hsel && hready && htrans[1];
   wire         wr_req    = addr_ok && hwrite;
   wire         rd_req    = addr_ok && !hwrite;
   wire  [7:0]  idx       = haddr[ARTP_IDX_SHIFT +: 8];   // Register index
   wire  [7:0]  wd        = hwdata[7:0];
   wire         wr_mode   = wr_pend_r && wr_addr_r == ARTP_OFS_MODE;
   wire         wr_flags  = wr_pend_r && wr_addr_r == ARTP_OFS_FLAGS;
   wire         wr_cfg    = wr_pend_r && wr_addr_r == ARTP_OFS_CLKEDGE;
   wire         wr_reload = wr_pend_r && wr_addr_r == ARTP_OFS_RELOAD;
   wire         wr_cmp    = wr_pend_r && wr_addr_r == ARTP_OFS_COMPARE;
   wire         wr_live   = wr_pend_r && wr_addr_r == ARTP_OFS_LIVE;

   // Field views
   artp_mode_t  mode;
   artp_src_t   src;
   assign mode = artp_mode_t'(mode_r[ARTP_B_MODE +: 2]);
   assign src  = artp_src_t'(cfg_r[ARTP_B_SRC +: 2]);
   wire  [2:0]  div_sel  = cfg_r[ARTP_B_DIV +: 3];
   wire         run      = mode_r[ARTP_B_EN];

   // ==========================================================
   // Input edge detection: a new pin level counts only once flops 2 and 3
   // agree, so a late-settling first flop never yields a false edge; the
   // edge is seen as soon as flop 3 takes a level held two cycles, with no extra latency
   wire         pin_agree = sync_r[1] == sync_r[2];
   wire         rise     = pin_agree && sync_r[2] && !pin_lvl_r;
   wire         fall     = pin_agree && !sync_r[2] && pin_lvl_r;
   wire         pol_edge = cfg_r[ARTP_B_SLPOL] ? fall : rise;
   wire         act_edge = cfg_r[ARTP_B_SLEN] && pol_edge;

   // Clock source tick; the reserved source never ticks
   wire         src_tick = (src == ARTP_SRC_INT) ||
                           (src == ARTP_SRC_DIV3 && div3_r == ARTP_DIV3_END) ||
                           (src == ARTP_SRC_PIN && rise);

   // Prescaler tap: ratio 2^div_sel; psc_r wraps modulo 128 so tap mask works
   wire  [6:0]  psc_inc  = psc_r + 7'h01;
   wire  [7:0]  tap_mask = (8'h01 << div_sel) - 8'h01;
   wire         cnt_tick = run && src_tick && ((psc_r & tap_mask[6:0]) == tap_mask[6:0]);

   // Event decode
   wire         wrap_ev   = cnt_tick && cnt_r == ARTP_CNT_MAX;
   wire         match_ev  = cnt_r == cmp_r;
   wire         cap_ev    = act_edge && (mode == ARTP_CAP || mode == ARTP_CAPRST);
   wire         extld_ev  = act_edge && mode == ARTP_EXTLD;
   wire         strobe_ld = wr_mode && wd[ARTP_B_LOAD];

   // ==========================================================
   // Counter and prescaler next state; loads win over counting
   logic [7:0]  cnt_nxt;
   logic [6:0]  psc_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      psc_nxt = psc_r;
      if (wr_live) begin
         cnt_nxt = wd;
         psc_nxt = '0;
      end else if (strobe_ld || extld_ev) begin
         cnt_nxt = reload_r;
         psc_nxt = '0;
      end else if (cap_ev && mode == ARTP_CAPRST) begin
         cnt_nxt = '0;
         psc_nxt = '0;
      end else if (wrap_ev) begin
         cnt_nxt = reload_r;
         psc_nxt = '0;
      end else if (run && src_tick) begin
         psc_nxt = psc_inc;
         if (cnt_tick) begin
            cnt_nxt = cnt_r + 8'h01;
         end
      end
   end

   // Counter, prescaler and divide-by-3
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r  <= '0;
         psc_r  <= '0;
         div3_r <= '0;
      end else begin
         cnt_r  <= cnt_nxt;
         psc_r  <= psc_nxt;
         div3_r <= (div3_r == ARTP_DIV3_END) ? 2'h0 : div3_r + 2'h1;
      end
   end

   // Input synchroniser and filtered level; reset level matches the idle pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_r    <= '0;
         pin_lvl_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], tim_in};
         if (pin_agree) begin
            pin_lvl_r <= sync_r[2];                   // Level accepted once stable
         end
      end
   end

   // ==========================================================
   // Register writes; the load strobe bit is never stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= ARTP_MODE_RST;
         cfg_r  <= '0;
         cmp_r  <= '0;
      end else begin
         if (wr_mode) begin
            mode_r <= {1'b0, wd[6:0]};
         end
         if (wr_cfg) begin
            cfg_r <= wd & ~(8'h01 << ARTP_B_RSV);     // Reserved bit held zero
         end
         if (wr_cmp) begin
            cmp_r <= wd;
         end
      end
   end

   // Reload/capture: capture has priority over a same-cycle write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reload_r <= '0;
      end else if (cap_ev) begin
         reload_r <= cnt_r;
      end else if (wr_reload) begin
         reload_r <= wd;
      end
   end

   // Live load mirrors the counter; no reset by design. Reads of the live
   // load register come from this mirror, which tracks every load path
   always_ff @(posedge hclk) begin
      live_r <= cnt_nxt;
   end

   // ==========================================================
   // Flags: a set in the same cycle beats the software clear
   logic [2:0]  set_v;
   logic [2:0]  keep_v;
   assign set_v  = {act_edge, match_ev, wrap_ev};
   assign keep_v = wr_flags ? wd[2:0] : 3'h7;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_r <= '0;
      end else begin
         flags_r <= (flags_r & keep_v) | set_v;
      end
   end

   // PWM waveform: overflow sets, match clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_r <= 1'b0;
      end else if (wrap_ev) begin
         pwm_r <= 1'b1;
      end else if (match_ev) begin
         pwm_r <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs from flops
   wire irq_nxt = (mode_r[ARTP_B_EIE] && flags_r[ARTP_B_EF]) ||
                  (mode_r[ARTP_B_MIE] && flags_r[ARTP_B_MF]) ||
                  (mode_r[ARTP_B_WIE] && flags_r[ARTP_B_WF]);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         out_r <= mode_r[ARTP_B_WOE] && pwm_r;
         irq_r <= irq_nxt;
      end
   end

   // ==========================================================
   // Bus slave: writes land at data phase, reads registered
   logic [7:0]  rd_mux;
   always_comb begin
      rd_mux = 8'h00;                                 // Unmapped reads zero
      unique case (idx)
         ARTP_OFS_MODE:    rd_mux = {1'b0, mode_r[6:0]};
         ARTP_OFS_FLAGS:   rd_mux = {5'h00, flags_r};
         ARTP_OFS_CLKEDGE: rd_mux = cfg_r;
         ARTP_OFS_RELOAD:  rd_mux = reload_r;
         ARTP_OFS_COMPARE: rd_mux = cmp_r;
         ARTP_OFS_LIVE:    rd_mux = live_r;
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         rdata_r   <= '0;
      end else begin
         wr_pend_r <= wr_req;
         wr_addr_r <= idx;
         if (rd_req) begin
            rdata_r <= {24'h00_0000, rd_mux};
         end
      end
   end

   assign hrdata    = rdata_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign tim_out   = out_r;
   assign irq       = irq_r;

   // ==========================================================
   // Assertions
   // Checks on a counter load skip the cycles in which a load of higher
   // priority owns the counter, in the same order as the next-state logic.
   // Flag sets are checked without exceptions, since a set always beats a clear; the wrap clear check skips a same-cycle wrap.
   // All checks but reset_mode_a sleep while reset is low.
   strobe_reads_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_req && idx == ARTP_OFS_MODE |=> hrdata[ARTP_B_LOAD] == 1'b0)
      else $error("load strobe read back nonzero");
   freeze_when_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !run && !wr_pend_r && !act_edge |=> $stable(cnt_r) && $stable(psc_r))
      else $error("counter moved while disabled");
   out_gated_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !mode_r[ARTP_B_WOE] |=> !tim_out)
      else $error("pwm pin driven while disabled");
   wrap_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wrap_ev |=> flags_r[ARTP_B_WF])
      else $error("wrap did not set flag");
   wrap_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wrap_ev && !wr_pend_r && !act_edge |=> cnt_r == $past(reload_r) && psc_r == 7'h00)
      else $error("wrap did not reload counter");
   match_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match_ev |=> flags_r[ARTP_B_MF])
      else $error("match flag not set");
   load_clears_psc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      strobe_ld |=> psc_r == 7'h00 && cnt_r == $past(reload_r))
      else $error("load strobe did not initialise");
   irq_combine_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_nxt |=> irq)
      else $error("interrupt not raised");
   irq_masked_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !mode_r[ARTP_B_EIE] && !mode_r[ARTP_B_MIE] && !mode_r[ARTP_B_WIE] |=> !irq)
      else $error("masked interrupt raised");
   reset_mode_a: assert property (@(posedge hclk)
      !hresetn |=> mode_r == ARTP_MODE_RST || hresetn)
      else $error("mode register not cleared");
   flag_one_keeps_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_flags && wd[ARTP_B_EF] && flags_r[ARTP_B_EF] |=> flags_r[ARTP_B_EF])
      else $error("writing one changed a flag");
   flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_flags && !wd[ARTP_B_WF] && !wrap_ev |=> !flags_r[ARTP_B_WF])
      else $error("writing zero left wrap flag set");
   edge_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      act_edge |=> flags_r[ARTP_B_EF])
      else $error("edge flag not set");
   pwm_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wrap_ev |=> pwm_r)
      else $error("overflow did not set waveform");

   // Counter load and capture paths
   capture_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_ev |=> reload_r == $past(cnt_r))
      else $error("capture did not copy counter");
   caprst_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_ev && mode == ARTP_CAPRST && !wr_pend_r |=> cnt_r == 8'h00 && psc_r == 7'h00)
      else $error("capture reset did not clear counter");
   extload_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      extld_ev && !wr_live |=> cnt_r == $past(reload_r) && psc_r == 7'h00)
      else $error("external load did not copy reload");
   live_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_live |=> cnt_r == $past(wd) && psc_r == 7'h00)
      else $error("live load write did not reach counter");

endmodule
